// *** bench/part_ext_model.sv ***
`timescale 1ns/10ps
module part_ext_model
(
   // Clock
   input wire logic pclk,
   // Driven pins
   output logic ext_clock_in,
   output logic [1:0] capture_input_pin
);
   // Pins idle low; count clock stands still between bursts
   initial
   begin
      ext_clock_in = 1'b0;
      capture_input_pin = 2'b00;
   end

   // Slow pulses, high 3 cycles and low 4 cycles, to clear the synchroniser
   task automatic pulses(input int n);
      repeat (n)
      begin
         @(posedge pclk);
         ext_clock_in <= 1'b1;
         repeat (3) @(posedge pclk);
         ext_clock_in <= 1'b0;
         repeat (3) @(posedge pclk);
      end
   endtask

   // One level change on a capture pin, then settle time
   task automatic drive(input int ch, input logic v);
      @(posedge pclk);
      capture_input_pin[ch] <= v;
      repeat (8) @(posedge pclk);
   endtask
endmodule

// *** bench/tb.sv ***
`timescale 1ns/10ps
module tb import part_pkg::*;;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [31:0] paddr, pwdata, prdata, d, a;
   logic ext_clock_in, overflow_irq;
   logic [1:0] capture_input_pin, pwm_pin, pwm_pin_oe, capture_irq;
   int fails, cmp_count, hi0, hi1;

   part_ext_model u_ext (.pclk(pclk), .ext_clock_in(ext_clock_in),
      .capture_input_pin(capture_input_pin));
   part_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext_clock_in(ext_clock_in),
      .capture_input_pin(capture_input_pin), .pwm_pin(pwm_pin),
      .pwm_pin_oe(pwm_pin_oe), .overflow_irq(overflow_irq),
      .capture_irq(capture_irq));

   // 100 ns clock
   always #50 pclk = ~pclk;

   // APB cycle; read data taken at the edge that samples pready high
   task automatic xfer(input logic w, input logic [7:0] idx,
      input logic [7:0] v);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= 32'(idx) << ADDR_SHIFT;
      pwdata <= {24'h00_0000, v};
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      d = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] v);
      xfer(1'b1, idx, v);
   endtask
   task automatic rd(input logic [7:0] idx);
      xfer(1'b0, idx, 8'h00);
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         fails++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rc(input logic [7:0] idx, input logic [7:0] e);
      rd(idx);
      chk($sformatf("reg %h", idx), {24'h00_0000, e}, d);
   endtask
   // High cycles of each pin over a window
   task automatic cnt(input int n);
      hi0 = 0;
      hi1 = 0;
      repeat (n)
      begin
         @(negedge pclk);
         hi0 += int'(pwm_pin[0]);
         hi1 += int'(pwm_pin[1]);
      end
   endtask
   task automatic test_done();
      $display("Comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Watchdog well beyond the expected run of about 4700 cycles
   initial
   begin
      repeat (40000) @(posedge pclk);
      fails++;
      test_done();
   end

   // Test sequence
   initial
   begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite} = 3'h0;
      paddr = 32'h0000_0000;
      pwdata = 32'h0000_0000;
      fails = 0;
      cmp_count = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 8'h14; i <= 8'h1d; i++)
         rc(8'(i), 8'h00);
      wr(IDX_DUTY1, 8'ha5);
      wr(IDX_DUTY0, 8'h5a);
      wr(IDX_RELOAD, 8'h3c);
      wr(IDX_PWMCTL, 8'hff);
      wr(8'h1d, 8'hff);
      rc(IDX_DUTY1, 8'ha5);
      rc(IDX_DUTY0, 8'h5a);
      rc(IDX_RELOAD, 8'h3c);
      rc(IDX_PWMCTL, 8'h33);
      rc(8'h1d, 8'h00);
      wr(IDX_CAR, 8'h40);
      rc(IDX_CAR, 8'h40);
      rc(IDX_CAR, 8'h40);
      chk("pready", 32'h0000_0001, 32'(pready));
      chk("pslverr", 32'h0000_0000, 32'(pslverr));
      $display("test registers done");
      // Two reads exactly 16 ticks apart at each divider setting
      wr(IDX_RELOAD, 8'h00);
      for (int k = 0; k < 8; k++)
      begin
         wr(IDX_TCS, 8'h08 | 8'(k << TCS_DIV_LO));
         wr(IDX_CAR, 8'h00);
         rd(IDX_CAR);
         a = d;
         repeat ((16 << k) - 3) @(posedge pclk);
         rd(IDX_CAR);
         chk("count step", 32'h0000_0010, d - a);
      end
      $display("test divider done");
      wr(IDX_RELOAD, 8'hf0);
      wr(IDX_CAR, 8'hfe);
      wr(IDX_TCS, 8'h0a);
      repeat (6) @(posedge pclk);
      wr(IDX_TCS, 8'h02);
      chk("ovf irq", 32'h0000_0001, 32'(overflow_irq));
      rd(IDX_CAR);
      chk("reloaded", 32'h0000_0001, 32'(d >= 32'h0000_00f0));
      rc(IDX_TCS, 8'h03);
      rc(IDX_TCS, 8'h02);
      chk("ovf irq", 32'h0000_0000, 32'(overflow_irq));
      wr(IDX_CAR, 8'hfe);
      wr(IDX_TCS, 8'h08);
      repeat (6) @(posedge pclk);
      wr(IDX_TCS, 8'h00);
      chk("masked irq", 32'h0000_0000, 32'(overflow_irq));
      rc(IDX_TCS, 8'h01);
      $display("test overflow done");
      // Period 16 ticks from reload f0
      wr(IDX_DUTY0, 8'h00);
      wr(IDX_DUTY1, 8'hff);
      wr(IDX_PWMCTL, 8'h30);
      wr(IDX_TCS, 8'h08);
      repeat (40) @(posedge pclk);
      cnt(32);
      chk("pwm0 high", 32'h0000_0020, hi0);
      chk("pwm1 high", 32'h0000_0000, hi1);
      chk("pwm oe", 32'h0000_0003, 32'(pwm_pin_oe));
      wr(IDX_DUTY0, 8'hf8);
      repeat (40) @(posedge pclk);
      cnt(32);
      chk("pwm0 high", 32'h0000_0012, hi0);
      wr(IDX_PWMCTL, 8'h31);
      cnt(32);
      chk("pwm0 inverted", 32'h0000_000e, hi0);
      wr(IDX_PWMCTL, 8'h20);
      cnt(4);
      chk("pwm oe", 32'h0000_0002, 32'(pwm_pin_oe));
      chk("pwm0 off", 32'h0000_0000, hi0);
      $display("test pwm done");
      wr(IDX_TCS, 8'h00);
      wr(IDX_CAR, 8'h55);
      wr(IDX_CCS, 8'h1c);
      u_ext.drive(0, 1'b1);
      chk("cap irq", 32'h0000_0001, 32'(capture_irq));
      rc(IDX_CAP1, 8'h55);
      wr(IDX_CAR, 8'h66);
      u_ext.drive(0, 1'b0);
      u_ext.drive(0, 1'b1);
      rc(IDX_CAP1, 8'h55);
      rc(IDX_CCS, 8'h1d);
      rc(IDX_CCS, 8'h1c);
      wr(IDX_CCS, 8'h10);
      u_ext.drive(1, 1'b1);
      rc(IDX_CCS, 8'h10);
      u_ext.drive(1, 1'b0);
      chk("cap irq", 32'h0000_0000, 32'(capture_irq));
      rc(IDX_CCS, 8'h12);
      rc(IDX_CAP2, 8'h66);
      wr(IDX_CCS, 8'hff);
      rc(IDX_CCS, 8'h3c);
      $display("test capture done");
      wr(IDX_TCS, 8'h80);
      wr(IDX_CAR, 8'h20);
      wr(IDX_TCS, 8'h88);
      u_ext.pulses(5);
      repeat (8) @(posedge pclk);
      rc(IDX_CAR, 8'h25);
      wr(IDX_TCS, 8'h00);
      rd(IDX_TCS);
      wr(IDX_RELOAD, 8'h77);
      wr(IDX_TCS, 8'h04);
      rc(IDX_CAR, 8'h77);
      rc(IDX_TCS, 8'h00);
      $display("test clock source done");
      test_done();
   end
endmodule

// *** design/part_pkg.sv ***
package part_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_DUTY1 = 8'h14;
   localparam logic [7:0] IDX_DUTY0 = 8'h15;
   localparam logic [7:0] IDX_PWMCTL = 8'h16;
   localparam logic [7:0] IDX_TCS = 8'h17;
   localparam logic [7:0] IDX_CAR = 8'h18;
   localparam logic [7:0] IDX_RELOAD = 8'h19;
   localparam logic [7:0] IDX_CCS = 8'h1a;
   localparam logic [7:0] IDX_CAP1 = 8'h1b;
   localparam logic [7:0] IDX_CAP2 = 8'h1c;
   localparam int ADDR_SHIFT = 2;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] BYTE_FULL = 8'hff;
   localparam logic [6:0] PRESC_ZERO = 7'h00;
   // Timer control/status bit positions
   localparam int TCS_EXT = 7;
   localparam int TCS_DIV_LO = 4;
   localparam int TCS_TCE = 3;
   localparam int TCS_FORCE_RELOAD = 2;
   localparam int TCS_OIE = 1;
   localparam int TCS_OVF = 0;
   // PWM control bit positions
   localparam int PWM_OE0 = 4;
   localparam int PWM_OE1 = 5;
   localparam int PWM_OP0 = 0;
   localparam int PWM_OP1 = 1;
   // Capture control/status bit positions
   localparam int CCS_SENS_LO = 4;
   localparam int CCS_IE_LO = 2;
   localparam int CCS_CF_LO = 0;

   // APB request bundle
   typedef struct packed {
      logic sel;
      logic enable;
      logic write;
      logic [31:0] addr;
      logic [31:0] wdata;
   } part_apb_req_t;

   // PWM pin bundle
   typedef struct packed {
      logic [1:0] level;
      logic [1:0] oe;
   } part_pwm_t;
endpackage

// *** design/part_timer.sv ***
// Operation
// R01 - ext_clock_select picks CPU or external clock
// R02 - Divider field divides by two to power
// R03 - count_enable 0 freezes counter and prescaler
// R04 - force_reload loads reload value, reads zero
// R05 - Overflow from FFh reloads, sets flag
// R06 - Reading timer control status clears flag
// R07 - Overflow request when flag and enable
// R08 - Counter access reads live, writes load
// R09 - Overflow drives enabled outputs active
// R10 - Output enables connect each channel pin
// R11 - Output high at or below compare
// R12 - Polarity change inverts output immediately
// R13 - Duty FFh gives 0, 00h gives 1
// R14 - Duty sets second edge, reload first
// R15 - Sensitivity bit selects capture edge
// R16 - Capture enables gate capture requests
// R17 - Capture sets flag, status read clears
// R18 - Top two capture status bits read zero
// R19 - Capture latch takes counter value
// R20 - Latch locked until status read
// R21 - Counter write clears prescaler too
// R22 - Compare copied from duty on overflow
// R23 - Counter steps on prescaler tick
// R24 - Inputs synchronised before edge detection
`timescale 1ns/10ps
module part_timer
   import part_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // External pins
   input wire logic ext_clock_in,
   input wire logic [1:0] capture_input_pin,
   output logic [1:0] pwm_pin,
   output logic [1:0] pwm_pin_oe,
   // Interrupt requests
   output logic overflow_irq,
   output logic [1:0] capture_irq
);

   part_apb_req_t req;
   part_pwm_t pwm_bus;
   logic [7:0] duty_value [2];
   logic [7:0] compare_value [2];
   logic [7:0] pwm_output_control;
   logic [7:0] tcs;
   logic [7:0] counter_access;
   logic [7:0] reload_value;
   logic [7:0] ccs;
   logic [7:0] capture_latch [2];
   logic [6:0] presc;
   logic [6:0] next_presc;
   logic [1:0] ext_sync;
   logic ext_prev;
   logic [1:0] cap_sync0;
   logic [1:0] cap_sync1;
   logic [1:0] cap_prev;
   logic [7:0] next_count;
   logic [1:0] cap_event;
   logic [1:0] pwm_raw;
   logic wr;
   logic rd;
   logic tick;
   logic ovf_evt;
   logic in_tick;
   logic [7:0] idx;

   // Word index from byte address
   function automatic logic [7:0] word_idx(input logic [31:0] a);
      word_idx = a[ADDR_SHIFT +: 8];
   endfunction

   assign req = '{sel: psel, enable: penable, write: pwrite,
                  addr: paddr, wdata: pwdata};
   assign idx = word_idx(req.addr);
   assign wr = req.sel && req.enable && req.write;
   assign rd = req.sel && req.enable && !req.write;
   // Zero wait states; unmapped words read zero, no error
   assign pready = 1'b1;
   assign pslverr = 1'b0;

   // Two-flop synchronisers; edge detect reads only the second flop
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ext_sync <= 2'b00;
         ext_prev <= 1'b0;
         cap_sync0 <= 2'b00;
         cap_sync1 <= 2'b00;
         cap_prev <= 2'b00;
      end
      else
      begin
         ext_sync <= {ext_sync[0], ext_clock_in}; // [R24]
         ext_prev <= ext_sync[1];
         cap_sync0 <= capture_input_pin; // [R24]
         cap_sync1 <= cap_sync0;
         cap_prev <= cap_sync1;
      end
   end

   // Input clock tick: every pclk, or rising external edge
   assign in_tick = tcs[TCS_EXT] ? (ext_sync[1] && !ext_prev)
                                 : 1'b1; // [R01]

   // Divider tap: tick when the low n prescaler bits wrap
   always_comb
   begin
      next_presc = presc + 7'd1;
      tick = 1'b0;
      if (tcs[TCS_TCE] && in_tick) // [R03]
      begin
         if (tcs[TCS_DIV_LO +: 3] == 3'd0)
            tick = 1'b1; // [R02]
         else
            tick = ((presc & ((7'd1 << tcs[TCS_DIV_LO +: 3]) - 7'd1))
                    == ((7'd1 << tcs[TCS_DIV_LO +: 3]) - 7'd1)); // [R02]
      end
   end

   assign ovf_evt = tick && (counter_access == BYTE_FULL); // [R05]

   // Prescaler; counter write or forced reload clears it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         presc <= PRESC_ZERO;
      else if ((wr && idx == IDX_CAR) ||
               (wr && idx == IDX_TCS && req.wdata[TCS_FORCE_RELOAD]))
         presc <= PRESC_ZERO; // [R04] [R21]
      else if (tcs[TCS_TCE] && in_tick)
         presc <= next_presc; // [R03]
   end

   // Next count; software load beats a coincident tick
   always_comb
   begin
      next_count = counter_access;
      if (wr && idx == IDX_CAR)
         next_count = req.wdata[7:0]; // [R08]
      else if (wr && idx == IDX_TCS && req.wdata[TCS_FORCE_RELOAD])
         next_count = reload_value; // [R04]
      else if (ovf_evt)
         next_count = reload_value; // [R05]
      else if (tick)
         next_count = counter_access + 8'd1; // [R23]
   end

   // Counter register; the waveform below reads its next value, next_count
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         counter_access <= BYTE_ZERO;
      else
         counter_access <= next_count;
   end

   // Timer control/status; overflow set wins over read clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         tcs <= BYTE_ZERO;
      else
      begin
         if (wr && idx == IDX_TCS)
         begin
            tcs[7:TCS_OIE] <= req.wdata[7:TCS_OIE];
            tcs[TCS_FORCE_RELOAD] <= 1'b0; // [R04]
         end
         if (ovf_evt)
            tcs[TCS_OVF] <= 1'b1; // [R05]
         else if (rd && idx == IDX_TCS)
            tcs[TCS_OVF] <= 1'b0; // [R06]
      end
   end
   assign overflow_irq = tcs[TCS_OVF] && tcs[TCS_OIE]; // [R07]

   // Plain software registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         duty_value[0] <= BYTE_ZERO;
         duty_value[1] <= BYTE_ZERO;
         pwm_output_control <= BYTE_ZERO;
         reload_value <= BYTE_ZERO;
      end
      else if (wr)
      begin
         if (idx == IDX_DUTY0)
            duty_value[0] <= req.wdata[7:0];
         else if (idx == IDX_DUTY1)
            duty_value[1] <= req.wdata[7:0];
         else if (idx == IDX_PWMCTL)
            pwm_output_control <= req.wdata[7:0] & 8'h33;
         else if (idx == IDX_RELOAD)
            reload_value <= req.wdata[7:0];
      end
   end

   // Compare shadow loads only at overflow, avoiding glitches
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         compare_value[0] <= BYTE_ZERO;
         compare_value[1] <= BYTE_ZERO;
      end
      else if (ovf_evt)
      begin
         compare_value[0] <= duty_value[0]; // [R22]
         compare_value[1] <= duty_value[1]; // [R22]
      end
   end

   // Waveform judged on the count being loaded, so the pin does not lag
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pwm_raw <= 2'b00;
      else
         for (int c = 0; c < 2; c++)
         begin
            if (compare_value[c] == BYTE_FULL)
               pwm_raw[c] <= 1'b0; // [R13]
            else if (compare_value[c] == BYTE_ZERO)
               pwm_raw[c] <= 1'b1; // [R13]
            else if (ovf_evt)
               pwm_raw[c] <= 1'b1; // [R09] [R14]
            else
               pwm_raw[c] <= (next_count <= compare_value[c]); // [R11]
         end
   end

   // Polarity applied after the flop so a change acts at once
   assign pwm_bus.level = pwm_raw ^ {pwm_output_control[PWM_OP1],
                                     pwm_output_control[PWM_OP0]}; // [R12]
   assign pwm_bus.oe = {pwm_output_control[PWM_OE1],
                        pwm_output_control[PWM_OE0]}; // [R10]
   assign pwm_pin = pwm_bus.level & pwm_bus.oe; // [R10]
   assign pwm_pin_oe = pwm_bus.oe; // [R10]

   // Edge selection per channel
   assign cap_event = (cap_sync1 & ~cap_prev & ccs[CCS_SENS_LO +: 2]) |
                      (~cap_sync1 & cap_prev & ~ccs[CCS_SENS_LO +: 2]); // [R15]

   // Capture status and latches; latch locked while flag set
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ccs <= BYTE_ZERO;
         capture_latch[0] <= BYTE_ZERO;
         capture_latch[1] <= BYTE_ZERO;
      end
      else
      begin
         if (wr && idx == IDX_CCS)
            ccs[5:CCS_IE_LO] <= req.wdata[5:CCS_IE_LO];
         for (int c = 0; c < 2; c++)
         begin
            if (cap_event[c] && !ccs[CCS_CF_LO + c])
            begin
               capture_latch[c] <= counter_access; // [R19] [R20]
               ccs[CCS_CF_LO + c] <= 1'b1; // [R17]
            end
            else if (rd && idx == IDX_CCS)
               ccs[CCS_CF_LO + c] <= 1'b0; // [R17]
         end
      end
   end
   assign capture_irq = ccs[CCS_CF_LO +: 2] & ccs[CCS_IE_LO +: 2]; // [R16]

   // Read mux; unmapped reads zero
   always_comb
   begin
      prdata = 32'h0000_0000;
      if (idx == IDX_DUTY1)
         prdata[7:0] = duty_value[1];
      else if (idx == IDX_DUTY0)
         prdata[7:0] = duty_value[0];
      else if (idx == IDX_PWMCTL)
         prdata[7:0] = pwm_output_control;
      else if (idx == IDX_TCS)
         prdata[7:0] = tcs & ~(8'h01 << TCS_FORCE_RELOAD); // [R04]
      else if (idx == IDX_CAR)
         prdata[7:0] = counter_access; // [R08]
      else if (idx == IDX_RELOAD)
         prdata[7:0] = reload_value;
      else if (idx == IDX_CCS)
         prdata[7:0] = {2'b00, ccs[5:0]}; // [R18]
      else if (idx == IDX_CAP1)
         prdata[7:0] = capture_latch[0];
      else if (idx == IDX_CAP2)
         prdata[7:0] = capture_latch[1];
   end

   // Checks
   sequence s_status_read;
      rd && idx == IDX_TCS && !ovf_evt;
   endsequence
   property p_ovf_reload;
      @(posedge pclk) disable iff (!presetn)
      (ovf_evt && !wr) |=> (counter_access == $past(reload_value));
   endproperty
   a_ovf_reload: assert property (p_ovf_reload) // [R05]
      else $error("overflow did not reload counter");
   property p_ovf_flag;
      @(posedge pclk) disable iff (!presetn)
      ovf_evt |=> tcs[TCS_OVF];
   endproperty
   a_ovf_flag: assert property (p_ovf_flag) // [R05]
      else $error("overflow flag not set");
   property p_ovf_clear;
      @(posedge pclk) disable iff (!presetn)
      s_status_read |=> !tcs[TCS_OVF];
   endproperty
   a_ovf_clear: assert property (p_ovf_clear) // [R06]
      else $error("status read did not clear flag");
   property p_ovf_irq;
      @(posedge pclk) disable iff (!presetn)
      overflow_irq == (tcs[TCS_OVF] && tcs[TCS_OIE]);
   endproperty
   a_ovf_irq: assert property (p_ovf_irq) // [R07]
      else $error("overflow request wrong");
   property p_freeze;
      @(posedge pclk) disable iff (!presetn)
      (!tcs[TCS_TCE] && !wr) |=> $stable(counter_access) && $stable(presc);
   endproperty
   a_freeze: assert property (p_freeze) // [R03]
      else $error("counter moved while disabled");
   property p_car_write;
      @(posedge pclk) disable iff (!presetn)
      (wr && idx == IDX_CAR) |=> counter_access == $past(req.wdata[7:0])
                                 && presc == PRESC_ZERO;
   endproperty
   a_car_write: assert property (p_car_write) // [R08]
      else $error("counter write not taken");
   property p_latch_hold;
      @(posedge pclk) disable iff (!presetn)
      ccs[CCS_CF_LO] |=> $stable(capture_latch[0]);
   endproperty
   a_latch_hold: assert property (p_latch_hold) // [R20]
      else $error("capture latch changed while flagged");
   property p_ccs_top;
      @(posedge pclk) disable iff (!presetn)
      (idx == IDX_CCS) |-> prdata[7:6] == 2'b00;
   endproperty
   a_ccs_top: assert property (p_ccs_top) // [R18]
      else $error("reserved capture bits not zero");
   property p_pin_off;
      @(posedge pclk) disable iff (!presetn)
      !pwm_pin_oe[0] |-> !pwm_pin[0];
   endproperty
   a_pin_off: assert property (p_pin_off) // [R10]
      else $error("disabled pin driven");

endmodule
